/* verilog/ppsl_params.svh */
// constants for the pin routing fabric and its selection lock
`ifndef PPSL_PARAMS_SVH
`define PPSL_PARAMS_SVH

`define PPSL_ADDR_W 6
`define PPSL_DATA_W 8
`define PPSL_SEL_W 5
`define PPSL_NUM_IN 28
`define PPSL_NUM_PIN 18
`define PPSL_NUM_SRC 32

`define PPSL_ADDR_LOCK 6'h00
`define PPSL_ADDR_IN_BASE 6'h01
`define PPSL_ADDR_OUT_BASE 6'h20

`define PPSL_LOCK_BIT 0
`define PPSL_LOCK_RST 1'b0
`define PPSL_SEL_RST 5'h00
`define PPSL_CODE_MODULATOR 5'h1f

`endif

/* verilog/ppsl_pkg.sv */
// types for the pin routing fabric
`include "ppsl_params.svh"
package ppsl_pkg;

    typedef logic [`PPSL_SEL_W-1:0] ppsl_sel_t;

    typedef struct packed {
        logic lock;
        logic [`PPSL_NUM_IN-1:0][`PPSL_SEL_W-1:0] in_sel;
        logic [`PPSL_NUM_PIN-1:0][`PPSL_SEL_W-1:0] out_sel;
        logic [`PPSL_NUM_PIN-1:0] sync1;
        logic [`PPSL_NUM_PIN-1:0] sync2;
        logic [`PPSL_NUM_PIN-1:0] sync3;
        logic [`PPSL_NUM_PIN-1:0] pin_lvl;
        logic [`PPSL_NUM_IN-1:0] periph_in;
        logic [`PPSL_NUM_PIN-1:0] pin_out;
        logic [`PPSL_NUM_PIN-1:0] pin_oe;
        logic [`PPSL_DATA_W-1:0] rd_data;
    } ppsl_state_t;

endpackage : ppsl_pkg

/* verilog/ppsl_top.sv */
// pin routing fabric: input and output selection registers with lock
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "ppsl_params.svh"
module ppsl_top
    import ppsl_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // register port
    input wire logic [`PPSL_ADDR_W-1:0] i_addr,
    input wire logic [`PPSL_DATA_W-1:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [`PPSL_DATA_W-1:0] o_rd_data,
    // port pins
    input wire logic [`PPSL_NUM_PIN-1:0] i_pin_in,
    input wire logic [`PPSL_NUM_PIN-1:0] i_pin_dir_oe,
    output logic [`PPSL_NUM_PIN-1:0] o_pin_out,
    output logic [`PPSL_NUM_PIN-1:0] o_pin_oe,
    // peripherals
    input wire logic [`PPSL_NUM_SRC-1:0] i_periph_out,
    input wire logic [`PPSL_NUM_SRC-1:0] i_periph_oe,
    input wire logic [`PPSL_NUM_SRC-1:0] i_periph_dir_ovr,
    output logic [`PPSL_NUM_IN-1:0] o_periph_in,
    output logic o_routing_frozen_flag
);

    localparam logic [`PPSL_ADDR_W-1:0] NUM_IN_A = `PPSL_ADDR_W'(`PPSL_NUM_IN);
    localparam logic [`PPSL_ADDR_W-1:0] NUM_PIN_A = `PPSL_ADDR_W'(`PPSL_NUM_PIN);

    ppsl_state_t q;
    ppsl_state_t d;

    function automatic logic is_in_addr(input logic [`PPSL_ADDR_W-1:0] a);
        is_in_addr = (a >= `PPSL_ADDR_IN_BASE) && (a < `PPSL_ADDR_IN_BASE + NUM_IN_A);
    endfunction : is_in_addr

    function automatic logic is_out_addr(input logic [`PPSL_ADDR_W-1:0] a);
        is_out_addr = (a >= `PPSL_ADDR_OUT_BASE) && (a < `PPSL_ADDR_OUT_BASE + NUM_PIN_A);
    endfunction : is_out_addr

    function automatic ppsl_sel_t addr_index(input logic [`PPSL_ADDR_W-1:0] a,
                                             input logic [`PPSL_ADDR_W-1:0] base);
        logic [`PPSL_ADDR_W-1:0] diff;
        diff = a - base;
        addr_index = diff[`PPSL_SEL_W-1:0];
    endfunction : addr_index

    // stored value behind any address, zero when unmapped
    function automatic logic [`PPSL_DATA_W-1:0] reg_value(input ppsl_state_t s,
                                                          input logic [`PPSL_ADDR_W-1:0] a);
        reg_value = '0;
        if (a == `PPSL_ADDR_LOCK) begin
            reg_value[`PPSL_LOCK_BIT] = s.lock;
        end else if (is_in_addr(a)) begin
            reg_value[`PPSL_SEL_W-1:0] = s.in_sel[addr_index(a, `PPSL_ADDR_IN_BASE)];
        end else if (is_out_addr(a)) begin
            reg_value[`PPSL_SEL_W-1:0] = s.out_sel[addr_index(a, `PPSL_ADDR_OUT_BASE)];
        end
    endfunction : reg_value

    // pin level for an input code; codes past the last pin give low
    function automatic logic pin_pick(input ppsl_sel_t code,
                                      input logic [`PPSL_NUM_PIN-1:0] lvl);
        pin_pick = 1'b0;
        if ({1'b0, code} < NUM_PIN_A) begin
            pin_pick = lvl[code];
        end
    endfunction : pin_pick

    // routing muxes, one per peripheral input and one per pin
    logic [`PPSL_NUM_IN-1:0] in_pick;
    logic [`PPSL_NUM_PIN-1:0] out_pick;
    logic [`PPSL_NUM_PIN-1:0] oe_pick;

    for (genvar gi = 0; gi < `PPSL_NUM_IN; gi++) begin : g_in_mux
        assign in_pick[gi] = pin_pick(q.in_sel[gi], q.pin_lvl);
    end

    for (genvar gp = 0; gp < `PPSL_NUM_PIN; gp++) begin : g_pin_mux
        assign out_pick[gp] = i_periph_out[q.out_sel[gp]];
        // peripheral direction wins over the programmed one
        assign oe_pick[gp] = i_periph_dir_ovr[q.out_sel[gp]] ? i_periph_oe[q.out_sel[gp]]
                                                             : i_pin_dir_oe[gp];
    end

    always_comb begin
        d = q;
        // three-stage sync; level moves only when stages two and three agree
        d.sync1 = i_pin_in;
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;
        d.pin_lvl = (~(q.sync2 ^ q.sync3) & q.sync3) | ((q.sync2 ^ q.sync3) & q.pin_lvl);
        d.periph_in = in_pick;
        d.pin_out = out_pick;
        d.pin_oe = oe_pick;
        d.rd_data = '0;
        if (i_rd) begin
            d.rd_data = reg_value(q, i_addr);
        end
        if (i_wr) begin
            if (i_addr == `PPSL_ADDR_LOCK) begin
                d.lock = i_wr_data[`PPSL_LOCK_BIT];
            end else if (is_in_addr(i_addr) && !q.lock) begin
                d.in_sel[addr_index(i_addr, `PPSL_ADDR_IN_BASE)] =
                    i_wr_data[`PPSL_SEL_W-1:0];
            end else if (is_out_addr(i_addr) && !q.lock) begin
                d.out_sel[addr_index(i_addr, `PPSL_ADDR_OUT_BASE)] =
                    i_wr_data[`PPSL_SEL_W-1:0];
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_rd_data = q.rd_data;
    assign o_pin_out = q.pin_out;
    assign o_pin_oe = q.pin_oe;
    assign o_periph_in = q.periph_in;
    assign o_routing_frozen_flag = q.lock;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst);

    property p_lock_blocks_write;
        q.lock && i_wr && (is_in_addr(i_addr) || is_out_addr(i_addr))
            |=> $stable(q.in_sel) && $stable(q.out_sel);
    endproperty
    a_lock_blocks_write: assert property (p_lock_blocks_write)
        else $error("selection changed while locked");

    property p_unlocked_write_lands;
        !q.lock && i_wr && (is_in_addr(i_addr) || is_out_addr(i_addr))
            |=> reg_value(q, $past(i_addr)) == {3'h0, $past(i_wr_data[`PPSL_SEL_W-1:0])};
    endproperty
    a_unlocked_write_lands: assert property (p_unlocked_write_lands)
        else $error("unlocked selection write not stored");

    property p_lock_write;
        i_wr && i_addr == `PPSL_ADDR_LOCK |=> q.lock == $past(i_wr_data[0])
            ##1 ($past(i_wr && i_addr == `PPSL_ADDR_LOCK) || $stable(q.lock));
    endproperty
    a_lock_write: assert property (p_lock_write)
        else $error("lock flag did not take bit 0");

    property p_lock_read_upper_zero;
        i_rd && i_addr == `PPSL_ADDR_LOCK
            |=> o_rd_data[7:1] == 7'h00 && o_rd_data[0] == $past(q.lock);
    endproperty
    a_lock_read_upper_zero: assert property (p_lock_read_upper_zero)
        else $error("lock readback wrong");

    property p_lock_reset;
        $rose(i_nrst) |-> !o_routing_frozen_flag;
    endproperty
    a_lock_reset: assert property (p_lock_reset)
        else $error("lock not clear after reset");

    property p_dir_override;
        q.out_sel[0] == `PPSL_CODE_MODULATOR && i_periph_dir_ovr[31]
            |=> o_pin_oe[0] == $past(i_periph_oe[31]);
    endproperty
    a_dir_override: assert property (p_dir_override)
        else $error("peripheral direction override ignored");

    property p_sel_read_upper_zero;
        i_rd && (is_in_addr(i_addr) || is_out_addr(i_addr))
            |=> o_rd_data[7:5] == 3'h0;
    endproperty
    a_sel_read_upper_zero: assert property (p_sel_read_upper_zero)
        else $error("selection upper bits not zero");

    property p_modulator_route;
        q.out_sel[0] == `PPSL_CODE_MODULATOR |=> o_pin_out[0] == $past(i_periph_out[31]);
    endproperty
    a_modulator_route: assert property (p_modulator_route)
        else $error("code 11111 did not route modulator");

    property p_input_route;
        ($stable(i_pin_in[0]) && q.in_sel[0] == 5'h00)[*6] |-> o_periph_in[0] == i_pin_in[0];
    endproperty
    a_input_route: assert property (p_input_route)
        else $error("peripheral input not following pin");

    property p_rd_idle_zero;
        !i_rd |=> o_rd_data == 8'h00;
    endproperty
    a_rd_idle_zero: assert property (p_rd_idle_zero)
        else $error("read data not cleared after read cycle");

    property p_unmapped_read_zero;
        i_rd && i_addr != `PPSL_ADDR_LOCK && !is_in_addr(i_addr) && !is_out_addr(i_addr)
            |=> o_rd_data == 8'h00;
    endproperty
    a_unmapped_read_zero: assert property (p_unmapped_read_zero)
        else $error("unmapped address read nonzero");

    property p_unmapped_write_ignored;
        i_wr && i_addr != `PPSL_ADDR_LOCK && !is_in_addr(i_addr) && !is_out_addr(i_addr)
            |=> $stable(q.in_sel) && $stable(q.out_sel) && $stable(q.lock);
    endproperty
    a_unmapped_write_ignored: assert property (p_unmapped_write_ignored)
        else $error("unmapped write changed state");

    property p_rd_no_state_change;
        i_rd && !i_wr |=> $stable(q.in_sel) && $stable(q.out_sel) && $stable(q.lock);
    endproperty
    a_rd_no_state_change: assert property (p_rd_no_state_change)
        else $error("read changed routing state");

    property p_lock_holds;
        !(i_wr && i_addr == `PPSL_ADDR_LOCK) |=> $stable(q.lock);
    endproperty
    a_lock_holds: assert property (p_lock_holds)
        else $error("lock flag moved without a lock write");

    property p_sel_write_keeps_lock;
        i_wr && (is_in_addr(i_addr) || is_out_addr(i_addr)) |=> $stable(q.lock);
    endproperty
    a_sel_write_keeps_lock: assert property (p_sel_write_keeps_lock)
        else $error("selection write changed lock flag");

    property p_lock_write_keeps_sel;
        i_wr && i_addr == `PPSL_ADDR_LOCK |=> $stable(q.in_sel) && $stable(q.out_sel);
    endproperty
    a_lock_write_keeps_sel: assert property (p_lock_write_keeps_sel)
        else $error("lock write changed a selection");

    property p_lock_round_trip;
        (i_wr && i_addr == `PPSL_ADDR_LOCK) ##1 !i_wr ##1 (i_rd && i_addr == `PPSL_ADDR_LOCK)
            |=> o_rd_data[`PPSL_LOCK_BIT] == $past(i_wr_data[`PPSL_LOCK_BIT], 3);
    endproperty
    a_lock_round_trip: assert property (p_lock_round_trip)
        else $error("lock readback differs from written bit");

    property p_in_readback;
        i_rd && is_in_addr(i_addr)
            |=> o_rd_data == {3'h0, $past(q.in_sel[addr_index(i_addr, `PPSL_ADDR_IN_BASE)])};
    endproperty
    a_in_readback: assert property (p_in_readback)
        else $error("input selection readback wrong");

    property p_out_readback;
        i_rd && is_out_addr(i_addr)
            |=> o_rd_data == {3'h0, $past(q.out_sel[addr_index(i_addr, `PPSL_ADDR_OUT_BASE)])};
    endproperty
    a_out_readback: assert property (p_out_readback)
        else $error("output selection readback wrong");

    property p_reset_outputs;
        $rose(i_nrst) |-> o_rd_data == 8'h00 && o_pin_out == '0 && o_pin_oe == '0
            && o_periph_in == '0;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs)
        else $error("outputs not clear after reset");

    property p_reset_selections;
        $rose(i_nrst) |-> q.in_sel == '0 && q.out_sel == '0;
    endproperty
    a_reset_selections: assert property (p_reset_selections)
        else $error("selections not clear after reset");

    // checks repeated for every pin
    for (genvar ap = 0; ap < `PPSL_NUM_PIN; ap++) begin : g_pin_chk
        property p_pin_modulator;
            q.out_sel[ap] == `PPSL_CODE_MODULATOR
                |=> o_pin_out[ap] == $past(i_periph_out[31]);
        endproperty
        a_pin_modulator: assert property (p_pin_modulator)
            else $error("pin not driven by modulator for its code");

        property p_pin_other_code;
            q.out_sel[ap] != `PPSL_CODE_MODULATOR
                |=> o_pin_out[ap] == $past(i_periph_out[q.out_sel[ap]]);
        endproperty
        a_pin_other_code: assert property (p_pin_other_code)
            else $error("pin not driven by selected peripheral");

        property p_pin_override;
            i_periph_dir_ovr[q.out_sel[ap]]
                |=> o_pin_oe[ap] == $past(i_periph_oe[q.out_sel[ap]]);
        endproperty
        a_pin_override: assert property (p_pin_override)
            else $error("pin direction not taken from peripheral");

        property p_pin_programmed_dir;
            !i_periph_dir_ovr[q.out_sel[ap]] |=> o_pin_oe[ap] == $past(i_pin_dir_oe[ap]);
        endproperty
        a_pin_programmed_dir: assert property (p_pin_programmed_dir)
            else $error("pin direction not taken from programmed setting");

        property p_pin_locked;
            q.lock |=> $stable(q.out_sel[ap]);
        endproperty
        a_pin_locked: assert property (p_pin_locked)
            else $error("output selection moved while locked");

        property p_sync_hold;
            q.sync2[ap] != q.sync3[ap] |=> $stable(q.pin_lvl[ap]);
        endproperty
        a_sync_hold: assert property (p_sync_hold)
            else $error("pin level moved while sync stages disagree");

        property p_sync_take;
            q.sync2[ap] == q.sync3[ap] |=> q.pin_lvl[ap] == $past(q.sync3[ap]);
        endproperty
        a_sync_take: assert property (p_sync_take)
            else $error("pin level missed agreed sync value");
    end

    // checks repeated for every peripheral input
    for (genvar ai = 0; ai < `PPSL_NUM_IN; ai++) begin : g_in_chk
        property p_in_route;
            {1'b0, q.in_sel[ai]} < NUM_PIN_A
                |=> o_periph_in[ai] == $past(q.pin_lvl[q.in_sel[ai]]);
        endproperty
        a_in_route: assert property (p_in_route)
            else $error("peripheral input not taken from selected pin");

        property p_in_no_pin;
            {1'b0, q.in_sel[ai]} >= NUM_PIN_A |=> !o_periph_in[ai];
        endproperty
        a_in_no_pin: assert property (p_in_no_pin)
            else $error("peripheral input high for code past last pin");

        property p_in_locked;
            q.lock |=> $stable(q.in_sel[ai]);
        endproperty
        a_in_locked: assert property (p_in_locked)
            else $error("input selection moved while locked");
    end

    c_lock_set: cover property (!q.lock ##1 q.lock);
    c_pin_override: cover property (q.out_sel[0] == `PPSL_CODE_MODULATOR && i_periph_dir_ovr[31]);
    c_locked_write: cover property (q.lock && i_wr && is_out_addr(i_addr));
    c_modulator_pin: cover property (q.out_sel[0] == `PPSL_CODE_MODULATOR && o_pin_out[0]);
    c_input_routed: cover property (q.in_sel[0] == 5'h00 && o_periph_in[0]);

endmodule : ppsl_top

/* verif/ppsl_far_model.sv */
// peripheral side model: outputs, wanted direction and override by code
`timescale 1ns/1ps
module ppsl_far_model (
    // control
    input wire logic i_clk,
    input wire logic i_step,
    // towards the fabric
    output logic [31:0] o_out,
    output logic [31:0] o_oe,
    output logic [31:0] o_ovr
);
    initial begin
        o_out = 32'h0;
        o_oe = 32'h0;
        o_ovr = 32'h0;
    end
    // new pattern only on request, so values hold while checked
    always @(posedge i_clk) begin
        if (i_step) begin
            o_out <= $urandom;
            o_oe <= $urandom;
            o_ovr <= $urandom;
        end
    end
endmodule : ppsl_far_model

/* verif/ppsl_bench.sv */
// self-checking bench for the pin routing fabric
`timescale 1ns/1ps
`include "ppsl_params.svh"
module ppsl_bench;
    logic clk = 0, nrst = 0, wr = 0, rd = 0, step = 0, frz;
    logic [5:0] addr = 6'h00;
    logic [7:0] wd = 8'h00, rdv, rdata;
    logic [17:0] pin_in = 18'h0, dir = 18'h0, pout, poe;
    logic [31:0] pe_out, pe_oe, pe_ovr;
    logic [27:0] per_in;
    int errors = 0, cmp_count = 0, p, c, i, s, k;
    always #5 clk = ~clk;
    ppsl_top ppsl_top_i (.i_sys_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wr_data(wd),
        .i_wr(wr), .i_rd(rd), .o_rd_data(rdata), .i_pin_in(pin_in), .i_pin_dir_oe(dir),
        .o_pin_out(pout), .o_pin_oe(poe), .i_periph_out(pe_out), .i_periph_oe(pe_oe),
        .i_periph_dir_ovr(pe_ovr), .o_periph_in(per_in), .o_routing_frozen_flag(frz));
    ppsl_far_model ppsl_far_model_i (.i_clk(clk), .i_step(step), .o_out(pe_out),
        .o_oe(pe_oe), .o_ovr(pe_ovr));
    function automatic logic [1:0] exp_pin(int pn, int cd);
        return {pe_ovr[cd] ? pe_oe[cd] : dir[pn], pe_out[cd]};
    endfunction : exp_pin
    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", n, exp, seen);
        end
    endtask : chk
    task wreg(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    task rreg(input logic [5:0] a, input logic [7:0] e, input string n);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(n, rdata, e);
    endtask : rreg
    task finish_test;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    initial begin
        #500000;
        errors++;
        finish_test;
    end
    initial begin
        void'($urandom(32'hc3afe1cd));
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        rreg(`PPSL_ADDR_LOCK, 8'h00, "lock rst");
        rreg(`PPSL_ADDR_OUT_BASE, 8'h00, "sel rst");
        wreg(`PPSL_ADDR_OUT_BASE, 8'hff);
        rreg(`PPSL_ADDR_OUT_BASE, 8'h1f, "sel bits");
        wreg(`PPSL_ADDR_LOCK, 8'hff);
        rreg(`PPSL_ADDR_LOCK, 8'h01, "lock bits");
        chk("frozen", frz, 1'b1);
        wreg(`PPSL_ADDR_OUT_BASE, 8'h03);
        wreg(`PPSL_ADDR_IN_BASE, 8'h03);
        rreg(`PPSL_ADDR_OUT_BASE, 8'h1f, "locked out");
        rreg(`PPSL_ADDR_IN_BASE, 8'h00, "locked in");
        wreg(6'h3f, 8'hff);
        rreg(6'h3f, 8'h00, "unmapped");
        wreg(`PPSL_ADDR_LOCK, 8'h00);
        rreg(`PPSL_ADDR_LOCK, 8'h00, "unlock");
        wreg(`PPSL_ADDR_LOCK, 8'h01);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        rreg(`PPSL_ADDR_LOCK, 8'h00, "lock rerst");
        for (k = 0; k < 40; k++) begin
            p = (k == 0) ? 0 : $urandom_range(17);
            c = (k == 0) ? 31 : $urandom_range(31);
            i = $urandom_range(27);
            s = (k == 1) ? 17 : $urandom_range(31);
            wreg(`PPSL_ADDR_OUT_BASE + 6'(p), 8'(c));
            wreg(`PPSL_ADDR_IN_BASE + 6'(i), 8'(s));
            step <= 1'b1;
            dir <= 18'($urandom);
            pin_in <= 18'($urandom);
            @(posedge clk);
            step <= 1'b0;
            repeat (7) @(posedge clk);
            #1;
            chk("pin", {poe[p], pout[p]}, exp_pin(p, c));
            chk("periph in", per_in[i], (s < 18) ? pin_in[s] : 1'b0);
        end
        finish_test;
    end
endmodule : ppsl_bench
